/* eeis_pkg.sv */
/*
 * eeis_pkg: constants, op codes and state type shared by the extended
 * instruction executor and its data memory.
 * assumes: single 40 MHz core clock, Avalon-MM register access, byte addresses.
 */
package eeis_pkg;
    // bus shape
    localparam int AV_AW = 8;             // byte address width of the slave
    localparam int AV_DW = 32;            // bus data width
    // register byte offsets
    localparam logic [7:0] REG_CMD    = 8'h00; // write starts an instruction
    localparam logic [7:0] REG_STATUS = 8'h04; // busy, zero flag, last skip
    localparam logic [7:0] REG_ACC    = 8'h08; // accumulator
    localparam logic [7:0] REG_TABLE_POINTER_LOW   = 8'h0c; // table pointer low
    localparam logic [7:0] REG_TABLE_POINTER_HIGH   = 8'h10; // table pointer high
    localparam logic [7:0] REG_TABLE_HIGH_LATCH   = 8'h14; // table high latch, read only
    localparam logic [7:0] REG_PAGE   = 8'h18; // current program page
    localparam logic [1:0] DMEM_SEL   = 2'h1;  // address[7:6] selecting 0x40..0x7c
    // data memory shape
    localparam int DMEM_AW    = 4;
    localparam int DMEM_DEPTH = 16;
    // command register fields
    localparam int CMD_OP_LSB  = 0;       // 4-bit op code
    localparam int CMD_ADR_LSB = 8;       // 4-bit data memory index
    localparam int CMD_BIT_LSB = 16;      // 3-bit bit select
    // status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ZERO_BIT = 1;
    localparam int ST_SKIP_BIT = 2;
    // reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [7:0] LAST_PAGE = 8'hff;
    localparam logic [7:0] TABLE_POINTER_LOW_STEP = 8'h01;
    // op codes
    localparam logic [3:0] NIBBLE_SWAP_TO_ACC_OP          = 4'h0;
    localparam logic [3:0] SKIP_IF_ZERO_OP                = 4'h1;
    localparam logic [3:0] SKIP_IF_ZERO_MOVE_OP           = 4'h2;
    localparam logic [3:0] SKIP_IF_BIT_ZERO_OP            = 4'h3;
    localparam logic [3:0] TABLE_READ_CURRENT_PAGE_OP     = 4'h4;
    localparam logic [3:0] TABLE_READ_LAST_PAGE_OP        = 4'h5;
    localparam logic [3:0] PREINC_TABLE_READ_OP           = 4'h6;
    localparam logic [3:0] PREINC_TABLE_READ_LAST_PAGE_OP = 4'h7;
    localparam logic [3:0] XOR_TO_ACC_OP                  = 4'h8;
    localparam logic [3:0] XOR_TO_MEM_OP                  = 4'h9;
    // executor states
    typedef enum logic [2:0] {EEIS_IDLE, EEIS_EXEC, EEIS_DUMMY, EEIS_FETCH, EEIS_STORE} eeis_state_t;
endpackage

/* eeis_dmem.sv */
/*
 * eeis_dmem: small byte-wide data memory in flip-flops, one write port and
 * two combinational read ports.
 * assumes: the caller resolves write priority before the single write port.
 */
module eeis_dmem (
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         rstn,
    // write port
    input  wire logic                         wr_en,
    input  wire logic [eeis_pkg::DMEM_AW-1:0] wr_idx,
    input  wire logic [7:0]                   wr_data,
    // read ports
    input  wire logic [eeis_pkg::DMEM_AW-1:0] rd_a_idx,
    output logic      [7:0]                   rd_a_data,
    input  wire logic [eeis_pkg::DMEM_AW-1:0] rd_b_idx,
    output logic      [7:0]                   rd_b_data
);
    // storage array
    logic [7:0] mem [eeis_pkg::DMEM_DEPTH];

    // byte store, cleared on reset so reads are never unknown
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < eeis_pkg::DMEM_DEPTH; i++) begin
                mem[i] <= eeis_pkg::RST_BYTE;
            end
        end else if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // read taps straight from the flops
    assign rd_a_data = mem[rd_a_idx];
    assign rd_b_data = mem[rd_b_idx];
endmodule // eeis_dmem

/* eeis_core.sv */
/*
 * eeis_core: executes a subset of extended instructions (nibble swap, zero
 * skips, table reads, xor) against a local data memory, accumulator, zero
 * flag and table pointers, commanded over an Avalon-MM slave.
 * assumes: program memory answers one clock after pm_rd with pm_rdata.
 */
// Behaviour
// [RQ1] swap nibbles of byte into accumulator
// [RQ2] skip next when addressed byte is zero
// [RQ3] skip instructions always take two cycles
// [RQ4] copy byte to accumulator, skip if zero
// [RQ5] skip next when selected bit is zero
// [RQ6] table read current page into memory, latch
// [RQ7] table read last page into memory, latch
// [RQ8] increment pointer low, then read table
// [RQ9] increment pointer low, then last-page read
// [RQ10] xor into accumulator, only zero flag
// [RQ11] xor into memory, only zero flag
// [RQ12] table reads keep flags, plain keeps pointers
module eeis_core (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rstn,
    // avalon-mm slave
    input  wire logic [eeis_pkg::AV_AW-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [eeis_pkg::AV_DW-1:0] avs_writedata,
    output logic      [eeis_pkg::AV_DW-1:0] avs_readdata,
    output logic                            avs_waitrequest,
    // program memory port
    output logic      [15:0]                pm_addr,
    output logic                            pm_rd,
    input  wire logic [15:0]                pm_rdata,
    // execution status
    output logic                            instr_done,
    output logic                            skip_taken,
    output logic                            busy
);
    // decode helpers
    function automatic logic is_skip(input logic [3:0] op);
        return op == eeis_pkg::SKIP_IF_ZERO_OP || op == eeis_pkg::SKIP_IF_ZERO_MOVE_OP ||
               op == eeis_pkg::SKIP_IF_BIT_ZERO_OP;
    endfunction
    function automatic logic is_table(input logic [3:0] op);
        return op[3:2] == 2'h1;
    endfunction
    function automatic logic is_preinc(input logic [3:0] op);
        return op == eeis_pkg::PREINC_TABLE_READ_OP ||
               op == eeis_pkg::PREINC_TABLE_READ_LAST_PAGE_OP;
    endfunction

    // executor state
    eeis_pkg::eeis_state_t state;         // sequencer
    logic [3:0]  op;                      // latched op code
    logic [eeis_pkg::DMEM_AW-1:0] maddr;  // latched data memory index
    logic [2:0]  bitsel;                  // latched bit select
    logic [7:0]  acc;                     // accumulator
    logic        zero;                    // zero flag
    logic [7:0]  table_pointer_low;       // table pointer low byte
    logic [7:0]  table_pointer_high;      // table pointer high byte
    logic [7:0]  table_high_latch;        // upper byte of last table read
    logic [7:0]  page;                    // current program page
    logic        skip_flag;               // result of the last skip test
    logic        ack;                     // bus answer cycle

    // bus decode
    wire req       = avs_read | avs_write;
    wire sel_cmd   = avs_address == eeis_pkg::REG_CMD;
    wire sel_stat  = avs_address == eeis_pkg::REG_STATUS;
    wire sel_acc   = avs_address == eeis_pkg::REG_ACC;
    wire sel_table_pointer_low  = avs_address == eeis_pkg::REG_TABLE_POINTER_LOW;
    wire sel_table_pointer_high  = avs_address == eeis_pkg::REG_TABLE_POINTER_HIGH;
    wire sel_table_high_latch  = avs_address == eeis_pkg::REG_TABLE_HIGH_LATCH;
    wire sel_page  = avs_address == eeis_pkg::REG_PAGE;
    wire sel_dmem  = avs_address[7:6] == eeis_pkg::DMEM_SEL && avs_address[1:0] == 2'h0;
    // writes wait while an instruction runs, so bus and executor never collide
    wire stall     = avs_write & busy;
    wire wr_fire   = avs_write & ack;
    wire start     = wr_fire & sel_cmd;
    wire [eeis_pkg::DMEM_AW-1:0] bus_idx = avs_address[eeis_pkg::DMEM_AW+1:2];

    // data memory taps
    logic [7:0] mem_byte;                 // operand at maddr
    logic [7:0] bus_byte;                 // byte seen by the bus
    wire [7:0] xor_val  = acc ^ mem_byte;
    wire [7:0] swap_val = {mem_byte[3:0], mem_byte[7:4]};   // see [RQ1]
    wire       test_zero = is_skip(op) && ((op == eeis_pkg::SKIP_IF_BIT_ZERO_OP) ?
                           ~mem_byte[bitsel] : mem_byte == eeis_pkg::RST_BYTE); // see [RQ2] [RQ5]
    wire [7:0] table_pointer_low_inc = table_pointer_low + eeis_pkg::TABLE_POINTER_LOW_STEP;
    wire [7:0] table_pointer_low_use = is_preinc(op) ? table_pointer_low_inc : table_pointer_low;           // see [RQ8]
    // page chosen per table op; preinc plain read uses the high pointer
    wire [7:0] page_use = (op == eeis_pkg::TABLE_READ_LAST_PAGE_OP ||
                           op == eeis_pkg::PREINC_TABLE_READ_LAST_PAGE_OP) ? eeis_pkg::LAST_PAGE :
                          (op == eeis_pkg::PREINC_TABLE_READ_OP) ? table_pointer_high : page;
    // executor write to memory: xor result or table low byte
    wire ex_we_xor  = state == eeis_pkg::EEIS_EXEC && op == eeis_pkg::XOR_TO_MEM_OP; // see [RQ11]
    wire ex_we_tbl  = state == eeis_pkg::EEIS_STORE;                                // see [RQ6]
    wire dm_we      = ex_we_xor | ex_we_tbl | (wr_fire & sel_dmem);
    wire [eeis_pkg::DMEM_AW-1:0] dm_idx = (ex_we_xor | ex_we_tbl) ? maddr : bus_idx;
    wire [7:0] dm_data = ex_we_xor ? xor_val : ex_we_tbl ? pm_rdata[7:0] : avs_writedata[7:0];

    // read mux, narrow registers in the low bits
    wire [31:0] status_word = {29'h0, skip_flag, zero, busy};
    wire [31:0] rd_word = sel_stat ? status_word : sel_acc ? {24'h0, acc} :
                          sel_table_pointer_low ? {24'h0, table_pointer_low} :
                          sel_table_pointer_high ? {24'h0, table_pointer_high} :
                          sel_table_high_latch ? {24'h0, table_high_latch} :
                          sel_page ? {24'h0, page} :
                          sel_dmem ? {24'h0, bus_byte} : 32'h0;

    eeis_dmem u_dmem (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .wr_en     (dm_we),
        .wr_idx    (dm_idx),
        .wr_data   (dm_data),
        .rd_a_idx  (maddr),
        .rd_a_data (mem_byte),
        .rd_b_idx  (bus_idx),
        .rd_b_data (bus_byte)
    );

    // one wait state per access; more while a write meets a running op
    assign avs_waitrequest = req & ~ack;
    assign busy = state != eeis_pkg::EEIS_IDLE;

    // bus answer and read data capture
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack <= req & ~ack & ~stall;
            if (avs_read & ~ack) begin
                avs_readdata <= rd_word;
            end
        end
    end

    // sequencer and architectural registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state              <= eeis_pkg::EEIS_IDLE;
            op                 <= eeis_pkg::NIBBLE_SWAP_TO_ACC_OP;
            maddr              <= '0;
            bitsel             <= 3'h0;
            acc                <= eeis_pkg::RST_BYTE;
            zero               <= 1'b0;
            table_pointer_low  <= eeis_pkg::RST_BYTE;
            table_pointer_high <= eeis_pkg::RST_BYTE;
            table_high_latch   <= eeis_pkg::RST_BYTE;
            page               <= eeis_pkg::RST_BYTE;
            skip_flag          <= 1'b0;
            pm_addr            <= 16'h0;
            pm_rd              <= 1'b0;
            instr_done         <= 1'b0;
            skip_taken         <= 1'b0;
        end else begin
            instr_done <= 1'b0;
            skip_taken <= 1'b0;
            pm_rd      <= 1'b0;
            // register writes only land while idle
            if (wr_fire && !busy) begin
                if (sel_acc)  acc                <= avs_writedata[7:0];
                if (sel_table_pointer_low) table_pointer_low  <= avs_writedata[7:0];
                if (sel_table_pointer_high) table_pointer_high <= avs_writedata[7:0];
                if (sel_page) page               <= avs_writedata[7:0];
                if (sel_stat) zero               <= avs_writedata[eeis_pkg::ST_ZERO_BIT];
            end
            case (state)
                eeis_pkg::EEIS_IDLE: begin
                    if (start) begin
                        op     <= avs_writedata[eeis_pkg::CMD_OP_LSB +: 4];
                        maddr  <= avs_writedata[eeis_pkg::CMD_ADR_LSB +: eeis_pkg::DMEM_AW];
                        bitsel <= avs_writedata[eeis_pkg::CMD_BIT_LSB +: 3];
                        state  <= eeis_pkg::EEIS_EXEC;
                    end
                end
                eeis_pkg::EEIS_EXEC: begin
                    if (is_skip(op)) begin
                        // zero flag untouched, dummy slot follows either way
                        skip_flag <= test_zero;                              // see [RQ2] [RQ5]
                        if (op == eeis_pkg::SKIP_IF_ZERO_MOVE_OP) acc <= mem_byte; // see [RQ4]
                        state <= eeis_pkg::EEIS_DUMMY;                       // see [RQ3]
                    end else if (is_table(op)) begin
                        // plain reads leave the pointer alone, no flag moves
                        if (is_preinc(op)) table_pointer_low <= table_pointer_low_inc;    // see [RQ8] [RQ9] [RQ12]
                        pm_addr <= {page_use, table_pointer_low_use};                     // see [RQ6] [RQ7]
                        pm_rd   <= 1'b1;
                        state   <= eeis_pkg::EEIS_FETCH;
                    end else begin
                        case (op)
                            eeis_pkg::NIBBLE_SWAP_TO_ACC_OP: acc <= swap_val; // see [RQ1]
                            eeis_pkg::XOR_TO_ACC_OP: begin
                                acc  <= xor_val;                             // see [RQ10]
                                zero <= xor_val == eeis_pkg::RST_BYTE;
                            end
                            eeis_pkg::XOR_TO_MEM_OP: zero <= xor_val == eeis_pkg::RST_BYTE; // see [RQ11]
                            default: ;                                       // unknown op: no effect
                        endcase
                        instr_done <= 1'b1;
                        state      <= eeis_pkg::EEIS_IDLE;
                    end
                end
                eeis_pkg::EEIS_DUMMY: begin
                    // dummy cycle in place of the skipped instruction
                    skip_taken <= skip_flag;                                 // see [RQ3]
                    instr_done <= 1'b1;
                    state      <= eeis_pkg::EEIS_IDLE;
                end
                eeis_pkg::EEIS_FETCH: begin
                    state <= eeis_pkg::EEIS_STORE;                           // memory answers in the next cycle
                end
                eeis_pkg::EEIS_STORE: begin
                    table_high_latch <= pm_rdata[15:8];                      // see [RQ6] [RQ7]
                    instr_done       <= 1'b1;
                    state            <= eeis_pkg::EEIS_IDLE;
                end
                default: state <= eeis_pkg::EEIS_IDLE;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire in_exec = state == eeis_pkg::EEIS_EXEC;

    a_swap_acc: assert property (in_exec && op == eeis_pkg::NIBBLE_SWAP_TO_ACC_OP |=> // see [RQ1]
        acc == {$past(mem_byte[3:0]), $past(mem_byte[7:4])} && $stable(zero))
        else $error("nibble swap result wrong");
    a_skip_zero: assert property (in_exec && op == eeis_pkg::SKIP_IF_ZERO_OP |=> // see [RQ2]
        skip_flag == ($past(mem_byte) == 8'h00) && $stable(zero) ##1 skip_taken == $past(skip_flag))
        else $error("byte skip decision wrong");
    a_skip_two: assert property (in_exec && is_skip(op) |=> // see [RQ3]
        !instr_done && state == eeis_pkg::EEIS_DUMMY ##1 instr_done && !busy)
        else $error("skip did not take two cycles");
    a_skip_move: assert property (in_exec && op == eeis_pkg::SKIP_IF_ZERO_MOVE_OP |=> // see [RQ4]
        acc == $past(mem_byte) && skip_flag == (acc == 8'h00) && $stable(zero))
        else $error("move skip wrong");
    a_skip_bit: assert property (in_exec && op == eeis_pkg::SKIP_IF_BIT_ZERO_OP |=> // see [RQ5]
        skip_flag == !$past(mem_byte[bitsel])) else $error("bit skip decision wrong");
    a_tbl_cur: assert property (in_exec && op == eeis_pkg::TABLE_READ_CURRENT_PAGE_OP |=> // see [RQ6]
        pm_rd && pm_addr == {page, table_pointer_low} ##2
        table_high_latch == $past(pm_rdata[15:8]) && instr_done)
        else $error("current page table read wrong");
    a_tbl_last: assert property (in_exec && op == eeis_pkg::TABLE_READ_LAST_PAGE_OP |=> // see [RQ7]
        pm_rd && pm_addr == {8'hff, table_pointer_low}) else $error("last page address wrong");
    a_tbl_preinc: assert property (in_exec && op == eeis_pkg::PREINC_TABLE_READ_OP |=> // see [RQ8]
        table_pointer_low == $past(table_pointer_low) + 8'h01 &&
        pm_addr == {table_pointer_high, table_pointer_low}) else $error("preinc read wrong");
    a_tbl_preinc_last: assert property (in_exec && op == eeis_pkg::PREINC_TABLE_READ_LAST_PAGE_OP
        |=> table_pointer_low == $past(table_pointer_low) + 8'h01 && // see [RQ9]
        pm_addr == {8'hff, table_pointer_low}) else $error("preinc last page read wrong");
    a_xor_acc: assert property (in_exec && op == eeis_pkg::XOR_TO_ACC_OP |=> // see [RQ10]
        acc == ($past(acc) ^ $past(mem_byte)) && zero == (acc == 8'h00))
        else $error("xor to accumulator wrong");
    a_xor_mem: assert property (in_exec && op == eeis_pkg::XOR_TO_MEM_OP |-> // see [RQ11]
        dm_we && dm_data == (acc ^ mem_byte) ##1 $stable(acc) && zero == ($past(dm_data) == 8'h00))
        else $error("xor to memory wrong");
    a_tbl_flags: assert property (in_exec && is_table(op) && !is_preinc(op) |=> // see [RQ12]
        ($stable(zero) && $stable(table_pointer_low)) [*3]) else $error("table read moved state");

    c_skip_taken: cover property (in_exec && is_skip(op) ##2 skip_taken);
    c_tbl_store:  cover property (state == eeis_pkg::EEIS_STORE && pm_rdata != 16'h0);
    c_xor_zero:   cover property (in_exec && op == eeis_pkg::XOR_TO_ACC_OP ##1 zero);
    c_stall:      cover property (avs_write && busy && avs_waitrequest);
endmodule // eeis_core

/* eeis_pmem_model.sv */
/*
 * eeis_pmem_model: behavioural program flash standing at the far side of
 * the executor's program port.
 * assumes: pm_rd is a one-cycle strobe and the word is wanted the cycle after.
 */
module eeis_pmem_model (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // program port
    input  wire logic [15:0] pm_addr,
    input  wire logic        pm_rd,
    output logic      [15:0] pm_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // each word is built from its address, so a wrong page or low byte shows
    // outside the answer cycle the word toggles, so stale data never passes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pm_rdata <= 16'h0000;
        end else if (pm_rd) begin
            pm_rdata <= {~pm_addr[7:0], pm_addr[15:8] ^ pm_addr[7:0]};
        end else begin
            pm_rdata <= ~pm_rdata;
        end
    end
endmodule // eeis_pmem_model

/* extended_instr_exec_subset_test.sv */
/*
 * extended_instr_exec_subset_test: directed bench for the executor, one task
 * per scenario, registers reached over avalon-mm.
 * assumes: program flash model beside the core, 40 MHz clock.
 */
module extended_instr_exec_subset_test;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and register bus
    logic        ref_clk;
    logic        rstn;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    // program port and execution status
    logic [15:0] pm_addr;
    logic        pm_rd;
    logic [15:0] pm_rdata;
    logic        instr_done;
    logic        skip_taken;
    logic        busy;
    // score keeping and last instruction outcome
    int          errors;
    int          samples_checked;
    logic        skipped;
    int          cyc;

    eeis_core uut (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .pm_addr, .pm_rd, .pm_rdata, .instr_done,
        .skip_taken, .busy);
    eeis_pmem_model pmem (.ref_clk, .rstn, .pm_addr, .pm_rd, .pm_rdata);

    // 25 ns period
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // waitrequest is judged at the rising edge, where the slave acts on the request
    task automatic wait_ack();
        int n;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 64);
        if (n >= 64) begin errors++; $display("ERROR waitrequest expected 0 seen 1"); end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
    endtask
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        @(posedge ref_clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        wait_ack();
        d = avs_readdata;
        avs_read <= 1'b0;
        chk(name, d, exp);
    endtask
    // data memory byte i sits at one word per byte from 0x40
    function automatic logic [7:0] dm(input int i);
        return 8'h40 + 8'(i * 4);
    endfunction
    // cyc counts cycles from the command taking effect to instr_done
    task automatic exec(input logic [3:0] op, input logic [3:0] idx, input logic [2:0] b);
        wr(eeis_pkg::REG_CMD, {13'h0000, b, 4'h0, idx, 4'h0, op});
        cyc = 0;
        do begin @(negedge ref_clk); cyc++; end while (instr_done !== 1'b1 && cyc < 16);
        skipped = skip_taken;
        chk("busy after done", 32'(busy), 32'h0);
    endtask

    task automatic t_reset();
        logic [7:0] regs[6] = '{eeis_pkg::REG_STATUS, eeis_pkg::REG_ACC, eeis_pkg::REG_TABLE_POINTER_LOW,
            eeis_pkg::REG_TABLE_POINTER_HIGH, eeis_pkg::REG_TABLE_HIGH_LATCH, eeis_pkg::REG_PAGE};
        foreach (regs[i]) rchk("reset value", regs[i], 32'h0);
        wr(8'h3c, 32'hff);
        rchk("unmapped", 8'h3c, 32'h0);
        wr(eeis_pkg::REG_TABLE_HIGH_LATCH, 32'h55);
        rchk("latch read only", eeis_pkg::REG_TABLE_HIGH_LATCH, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_swap();
        wr(eeis_pkg::REG_STATUS, 32'h2);
        wr(dm(3), 32'ha5);
        wr(eeis_pkg::REG_ACC, 32'h11);
        exec(eeis_pkg::NIBBLE_SWAP_TO_ACC_OP, 4'h3, 3'h0);
        chk("swap cycles", 32'(cyc), 32'd2);
        rchk("swap acc", eeis_pkg::REG_ACC, 32'h5a);
        rchk("swap mem", dm(3), 32'ha5);
        rchk("swap flags", eeis_pkg::REG_STATUS, 32'h2);
        $display("test swap done");
    endtask
    // zero, lowest non-zero byte and the top bit alone
    task automatic t_skip();
        logic [7:0] v[3] = '{8'h00, 8'h01, 8'h80};
        foreach (v[i]) begin
            wr(dm(5), {24'h0, v[i]});
            exec(eeis_pkg::SKIP_IF_ZERO_OP, 4'h5, 3'h0);
            chk("skip zero", 32'(skipped), 32'(v[i] == 8'h00));
            chk("skip cycles", 32'(cyc), 32'd3);
            rchk("skip status", eeis_pkg::REG_STATUS, {29'h0, v[i] == 8'h00, 2'b10});
            wr(eeis_pkg::REG_ACC, 32'hff);
            exec(eeis_pkg::SKIP_IF_ZERO_MOVE_OP, 4'h5, 3'h0);
            chk("move skip", 32'(skipped), 32'(v[i] == 8'h00));
            chk("move cycles", 32'(cyc), 32'd3);
            rchk("move acc", eeis_pkg::REG_ACC, {24'h0, v[i]});
        end
        $display("test skip done");
    endtask
    task automatic t_bit();
        wr(dm(7), 32'h7e);
        for (int b = 0; b < 8; b++) begin
            exec(eeis_pkg::SKIP_IF_BIT_ZERO_OP, 4'h7, 3'(b));
            chk("bit skip", 32'(skipped), 32'(b == 0 || b == 7));
            chk("bit cycles", 32'(cyc), 32'd3);
        end
        $display("test bit done");
    endtask
    // pointer starts at 0xfe so the two increments cross the 0xff wrap
    task automatic t_table();
        logic [7:0]  lo;
        logic [7:0]  pg;
        logic [15:0] w;
        lo = 8'hfe;
        wr(eeis_pkg::REG_PAGE, 32'h12);
        wr(eeis_pkg::REG_TABLE_POINTER_HIGH, 32'h34);
        wr(eeis_pkg::REG_TABLE_POINTER_LOW, 32'hfe);
        for (int k = 0; k < 4; k++) begin
            if (k >= 2) lo = lo + 8'h01;
            pg = (k == 0) ? 8'h12 : (k == 2) ? 8'h34 : 8'hff;
            w = {~lo, pg ^ lo};
            exec(eeis_pkg::TABLE_READ_CURRENT_PAGE_OP + 4'(k), 4'(k + 8), 3'h0);
            chk("table cycles", 32'(cyc), 32'd4);
            rchk("table mem", dm(k + 8), {24'h0, w[7:0]});
            rchk("table latch", eeis_pkg::REG_TABLE_HIGH_LATCH, {24'h0, w[15:8]});
            rchk("table pointer", eeis_pkg::REG_TABLE_POINTER_LOW, {24'h0, lo});
            rchk("table flags", eeis_pkg::REG_STATUS, 32'h6);
        end
        $display("test table done");
    endtask
    // zero flag seen going both ways
    task automatic t_xor();
        wr(eeis_pkg::REG_STATUS, 32'h0);
        wr(eeis_pkg::REG_ACC, 32'h3c);
        wr(dm(2), 32'h3c);
        exec(eeis_pkg::XOR_TO_ACC_OP, 4'h2, 3'h0);
        rchk("xor acc", eeis_pkg::REG_ACC, 32'h0);
        rchk("xor acc mem", dm(2), 32'h3c);
        rchk("xor acc flag", eeis_pkg::REG_STATUS, 32'h6);
        wr(eeis_pkg::REG_ACC, 32'h0f);
        exec(eeis_pkg::XOR_TO_MEM_OP, 4'h2, 3'h0);
        rchk("xor mem", dm(2), 32'h33);
        rchk("xor mem acc", eeis_pkg::REG_ACC, 32'h0f);
        rchk("xor mem flag", eeis_pkg::REG_STATUS, 32'h4);
        $display("test xor done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        errors = 0;
        samples_checked = 0;
        rstn = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_swap();
        t_skip();
        t_bit();
        t_table();
        t_xor();
        end_of_test();
    end
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        $display("ERROR watchdog expected finish seen hang");
        end_of_test();
    end
endmodule // extended_instr_exec_subset_test
